// *** lcc_pkg.sv ***
// Constants and decode functions for the lamp controller configuration registers.
`default_nettype none
package lcc_pkg;

  // Register addresses on the serial register port.
  localparam logic [7:0] ADDR_FAULT_SRC = 8'hF4;
  localparam logic [7:0] ADDR_RANGE_SMP = 8'hF5;

  // Factory defaults; only the low sample rate bit starts at one.
  localparam logic [7:0] RST_FAULT_SRC  = 8'h00;
  localparam logic [7:0] RST_RANGE_SMP  = 8'h08;
  // Bits 5 and 6 of the second register are reserved and read as zero.
  localparam logic [7:0] MASK_RANGE_SMP = 8'h9F;

  // Field positions in fault_and_source_control.
  localparam int BIT_OC_EN       = 0;
  localparam int BIT_DIM_OSC_SRC = 1;
  localparam int BIT_LAMP_SRC    = 2;
  localparam int BIT_DIM_SIG_SRC = 3;
  localparam int BIT_RAMP_OUT    = 4;
  localparam int BIT_RETRY_DIS   = 5;
  localparam int BIT_FAULT_SCOPE = 6;
  localparam int BIT_BURST_DIS   = 7;

  // Field positions in range_and_sampling_control.
  localparam int BIT_UMEM_PERMIT = 0;
  localparam int BIT_DIM_RANGE   = 1;
  localparam int BIT_SAMPLE_RATE = 3;
  localparam int BIT_POWERDOWN   = 7;

  // Band constant k in kilohm times kilohertz per range code.
  localparam logic [3:0] K_BAND0 = 4'h1;
  localparam logic [3:0] K_BAND1 = 4'h2;
  localparam logic [3:0] K_BAND2 = 4'h4;
  localparam logic [3:0] K_BAND3 = 4'h8;

  // Band limits in tenths of a hertz: 22.5-55, 45-110, 90-220, 180-440.
  localparam logic [15:0] BAND0_MIN_DHZ = 16'h00E1;
  localparam logic [15:0] BAND0_MAX_DHZ = 16'h0226;
  localparam logic [15:0] BAND1_MIN_DHZ = 16'h01C2;
  localparam logic [15:0] BAND1_MAX_DHZ = 16'h044C;
  localparam logic [15:0] BAND2_MIN_DHZ = 16'h0384;
  localparam logic [15:0] BAND2_MAX_DHZ = 16'h0898;
  localparam logic [15:0] BAND3_MIN_DHZ = 16'h0708;
  localparam logic [15:0] BAND3_MAX_DHZ = 16'h1130;

  // Lamp cycles between feedback samples per sample rate code.
  localparam logic [5:0] SMP_DIV0 = 6'h04;
  localparam logic [5:0] SMP_DIV1 = 6'h08;
  localparam logic [5:0] SMP_DIV2 = 6'h10;
  localparam logic [5:0] SMP_DIV3 = 6'h20;

  function automatic logic [3:0] bandK(input logic [1:0] code);
    unique case (code)
      2'h0: bandK = K_BAND0;
      2'h1: bandK = K_BAND1;
      2'h2: bandK = K_BAND2;
      2'h3: bandK = K_BAND3;
    endcase
  endfunction

  function automatic logic [5:0] sampleDiv(input logic [1:0] code);
    unique case (code)
      2'h0: sampleDiv = SMP_DIV0;
      2'h1: sampleDiv = SMP_DIV1;
      2'h2: sampleDiv = SMP_DIV2;
      2'h3: sampleDiv = SMP_DIV3;
    endcase
  endfunction

endpackage
`default_nettype wire

// *** lcc_sample_divider.sv ***
// Lamp cycle divider that paces the lamp current feedback samples.
`timescale 1ns/1ps
`default_nettype none
module lcc_sample_divider (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic       clear,
  input  wire logic       lampTick,
  input  wire logic [1:0] rateCode,
  output var  logic       sampleStrobe
);

  logic [5:0] count;
  logic [5:0] next_count;
  logic       next_sampleStrobe;

  always_comb begin
    next_count        = count;
    next_sampleStrobe = 1'b0;
    if (clear) begin
      next_count = 6'h00;
    end else if (lampTick) begin
      // A rate change takes effect at once; a count already past the new
      // limit strobes and restarts from zero on the next lamp tick.
      if (count >= lcc_pkg::sampleDiv(rateCode) - 6'h01) begin // [R14]
        next_count        = 6'h00;
        next_sampleStrobe = 1'b1;
      end else begin
        next_count = count + 6'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count        <= 6'h00;
      sampleStrobe <= 1'b0;
    end else if (clkEn) begin
      count        <= next_count;
      sampleStrobe <= next_sampleStrobe;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_strobe_pace;
    clkEn && !clear && lampTick && rateCode == 2'h0 && count == 6'h03
      |=> sampleStrobe && count == 6'h00;
  endproperty
  a_strobe_pace: assert property (p_strobe_pace) // [R14]
    else $error("sample strobe missed after four lamp cycles");

endmodule // lcc_sample_divider
`default_nettype wire

// *** lamp_ctrl_config_regs.sv ***
// Configuration registers of the dual-channel lamp controller.
// Functional notes
// [R1] Overcurrent conditions count as faults only while the overcurrent enable is set.
// [R2] Dimming oscillator uses its pin resistor at 0, external clock at 1.
// [R3] Lamp frequency internal and driven on lamp sync pin at 0, input at 1.
// [R4] Burst dimming internal and driven on dim sync pin at 0, external at 1.
// [R5] Ramp output select: 0 drives burst dimming, 1 drives ramp on dim sync.
// [R6] Autoretry clears faults while retry disable is 0; suppressed at 1.
// [R7] Fault scope 0 stops failing channel only; 1 stops both channels.
// [R8] Burst dimming runs while its disable bit is 0, off at 1.
// [R9] User memory writes rejected unless the write permit bit is 1.
// [R10] Two-bit range picks dimming band 22.5-55, 45-110, 90-220, 180-440 Hz.
// [R11] Software sets the range to the band holding any external dimming clock.
// [R12] Resistor mode band constant k is 1, 2, 4 or 8 per range code.
// [R13] Two-bit sample rate field; its low bit resets to 1.
// [R14] Sample rate codes sample feedback every 4, 8, 16, 32 lamp cycles.
// [R15] Powerdown bit OR pin resets controller, clears faults, keeps register port.
// [R16] Both registers reset to defaults and read back every defined bit.
`timescale 1ns/1ps
`default_nettype none
module lamp_ctrl_config_regs (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic [7:0] regAddr,
  input  wire logic       regWrEn,
  input  wire logic [7:0] regWrData,
  input  wire logic       regRdEn,
  output var  logic [7:0] regRdData,
  input  wire logic       powerdownPin,
  input  wire logic       dimOscPinIn,
  input  wire logic       lampSyncPinIn,
  output var  logic       lampSyncPinOut,
  output var  logic       lampSyncOeN,
  input  wire logic       dimSyncPinIn,
  output var  logic       dimSyncPinOut,
  output var  logic       dimSyncOeN,
  input  wire logic       lampFreqInt,
  input  wire logic       burstPwmInt,
  input  wire logic       rampInt,
  input  wire logic [1:0] faultIn,
  input  wire logic [1:0] overcurrentIn,
  input  wire logic       retryPulse,
  input  wire logic       userMemWrReq,
  output var  logic       controllerReset,
  output var  logic       dimOscExternal,
  output var  logic       dimOscExtClk,
  output var  logic [3:0] dimBandK,
  output var  logic       lampFreq,
  output var  logic       burstDimPwm,
  output var  logic       retryEnable,
  output var  logic [1:0] chanShutdown,
  output var  logic       userMemWrAccept,
  output var  logic       userMemWrReject,
  output var  logic       sampleStrobe
);

  // Pin synchronisers: bit 0 power-down, 1 dim osc, 2 lamp sync, 3 dim sync.
  logic [3:0] syncFirst;
  logic [3:0] syncSecond;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      syncFirst  <= 4'h0;
      syncSecond <= 4'h0;
    end else if (clkEn) begin
      syncFirst  <= {dimSyncPinIn, lampSyncPinIn, dimOscPinIn, powerdownPin};
      syncSecond <= syncFirst;
    end
  end

  // Register file.
  logic [7:0] faultSrcCtrl;
  logic [7:0] rangeSmpCtrl;
  logic [7:0] next_faultSrcCtrl;
  logic [7:0] next_rangeSmpCtrl;
  logic [7:0] next_regRdData;

  always_comb begin
    next_faultSrcCtrl = faultSrcCtrl;
    next_rangeSmpCtrl = rangeSmpCtrl;
    next_regRdData    = regRdData;
    if (regWrEn) begin
      unique case (regAddr)
        lcc_pkg::ADDR_FAULT_SRC: next_faultSrcCtrl = regWrData; // [R16]
        lcc_pkg::ADDR_RANGE_SMP: begin
          next_rangeSmpCtrl = regWrData & lcc_pkg::MASK_RANGE_SMP; // [R16]
        end
        default: ;
      endcase
    end
    // Reads see the value held before a write in the same cycle.
    if (regRdEn) begin
      unique case (regAddr)
        lcc_pkg::ADDR_FAULT_SRC: next_regRdData = faultSrcCtrl; // [R16]
        lcc_pkg::ADDR_RANGE_SMP: next_regRdData = rangeSmpCtrl; // [R16]
        default:                 next_regRdData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultSrcCtrl <= lcc_pkg::RST_FAULT_SRC; // [R16]
      rangeSmpCtrl <= lcc_pkg::RST_RANGE_SMP; // [R13]
      regRdData    <= 8'h00;
    end else if (clkEn) begin
      faultSrcCtrl <= next_faultSrcCtrl;
      rangeSmpCtrl <= next_rangeSmpCtrl;
      regRdData    <= next_regRdData;
    end
  end

  // Decoded configuration fields.
  logic       ocEn;
  logic       dimOscSel;
  logic       lampSrcSel;
  logic       dimSigSel;
  logic       rampSel;
  logic       retryDis;
  logic       scopeSel;
  logic       burstDis;
  logic       memPermit;
  logic [1:0] dimRange;
  logic [1:0] rateCode;
  logic       pdNow;

  always_comb begin
    ocEn      = faultSrcCtrl[lcc_pkg::BIT_OC_EN];
    dimOscSel = faultSrcCtrl[lcc_pkg::BIT_DIM_OSC_SRC];
    lampSrcSel = faultSrcCtrl[lcc_pkg::BIT_LAMP_SRC];
    dimSigSel = faultSrcCtrl[lcc_pkg::BIT_DIM_SIG_SRC];
    rampSel   = faultSrcCtrl[lcc_pkg::BIT_RAMP_OUT];
    retryDis  = faultSrcCtrl[lcc_pkg::BIT_RETRY_DIS];
    scopeSel  = faultSrcCtrl[lcc_pkg::BIT_FAULT_SCOPE];
    burstDis  = faultSrcCtrl[lcc_pkg::BIT_BURST_DIS];
    memPermit = rangeSmpCtrl[lcc_pkg::BIT_UMEM_PERMIT];
    dimRange  = rangeSmpCtrl[lcc_pkg::BIT_DIM_RANGE +: 2];
    rateCode  = rangeSmpCtrl[lcc_pkg::BIT_SAMPLE_RATE +: 2];
    pdNow     = syncSecond[0] | rangeSmpCtrl[lcc_pkg::BIT_POWERDOWN]; // [R15]
  end

  // Fault handling and channel shutdown.
  logic [1:0] faultLatched;
  logic [1:0] next_faultLatched;
  logic [1:0] next_chanShutdown;

  always_comb begin
    next_faultLatched = faultLatched;
    if (retryPulse && !retryDis) begin
      next_faultLatched = 2'h0; // [R6]
    end
    // A new fault in the retry cycle survives the clear.
    next_faultLatched = next_faultLatched | faultIn
                        | (overcurrentIn & {2{ocEn}}); // [R1]
    if (pdNow) begin
      next_faultLatched = 2'h0; // [R15]
    end
    if (pdNow) begin
      next_chanShutdown = 2'h3; // [R15]
    end else if (scopeSel) begin
      next_chanShutdown = {2{|next_faultLatched}}; // [R7]
    end else begin
      next_chanShutdown = next_faultLatched; // [R7]
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      faultLatched <= 2'h0;
      chanShutdown <= 2'h0;
    end else if (clkEn) begin
      faultLatched <= next_faultLatched;
      chanShutdown <= next_chanShutdown;
    end
  end

  // Source selection and pin drive.
  logic       next_lampSyncPinOut;
  logic       next_lampSyncOeN;
  logic       next_dimSyncPinOut;
  logic       next_dimSyncOeN;
  logic       next_lampFreq;
  logic       next_burstDimPwm;
  logic       next_dimOscExtClk;
  logic       lampTick;

  always_comb begin
    next_lampFreq = lampSrcSel ? syncSecond[2] : lampFreqInt; // [R3]
    next_lampSyncPinOut = lampFreqInt; // [R3]
    // Pins are released in power-down so a cascaded master can take them.
    next_lampSyncOeN = lampSrcSel | pdNow; // [R3]
    next_dimSyncPinOut = rampSel ? rampInt : burstPwmInt; // [R5]
    next_dimSyncOeN = dimSigSel | pdNow; // [R4]
    // With dimming off the lamps run steadily at full duty.
    if (burstDis) begin
      next_burstDimPwm = 1'b1; // [R8]
    end else begin
      next_burstDimPwm = dimSigSel ? syncSecond[3] : burstPwmInt; // [R4]
    end
    next_dimOscExtClk = dimOscSel & syncSecond[1]; // [R2]
    lampTick = next_lampFreq & ~lampFreq;
  end

  // Per-cycle strobes and configuration outputs.
  logic       next_userMemWrAccept;
  logic       next_userMemWrReject;
  logic [3:0] next_dimBandK;

  always_comb begin
    next_userMemWrAccept = userMemWrReq & memPermit; // [R9]
    next_userMemWrReject = userMemWrReq & ~memPermit; // [R9]
    next_dimBandK        = lcc_pkg::bandK(dimRange); // [R10] [R12]
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lampSyncPinOut  <= 1'b0;
      lampSyncOeN     <= 1'b1;
      dimSyncPinOut   <= 1'b0;
      dimSyncOeN      <= 1'b1;
      lampFreq        <= 1'b0;
      burstDimPwm     <= 1'b0;
      dimOscExtClk    <= 1'b0;
      dimOscExternal  <= 1'b0;
      dimBandK        <= lcc_pkg::K_BAND0;
      retryEnable     <= 1'b0;
      controllerReset <= 1'b1;
      userMemWrAccept <= 1'b0;
      userMemWrReject <= 1'b0;
    end else if (clkEn) begin
      lampSyncPinOut  <= next_lampSyncPinOut;
      lampSyncOeN     <= next_lampSyncOeN;
      dimSyncPinOut   <= next_dimSyncPinOut;
      dimSyncOeN      <= next_dimSyncOeN;
      lampFreq        <= next_lampFreq;
      burstDimPwm     <= next_burstDimPwm;
      dimOscExtClk    <= next_dimOscExtClk;
      dimOscExternal  <= dimOscSel; // [R2]
      dimBandK        <= next_dimBandK;
      retryEnable     <= ~retryDis; // [R6]
      controllerReset <= pdNow; // [R15]
      userMemWrAccept <= next_userMemWrAccept;
      userMemWrReject <= next_userMemWrReject;
    end
  end

  lcc_sample_divider u_sample_divider (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .clkEn        (clkEn),
    .clear        (pdNow),
    .lampTick     (lampTick),
    .rateCode     (rateCode),
    .sampleStrobe (sampleStrobe)
  ); // [R14]

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_wr_fault_src;
    clkEn && regWrEn && regAddr == lcc_pkg::ADDR_FAULT_SRC
      |=> faultSrcCtrl == $past(regWrData);
  endproperty
  a_wr_fault_src: assert property (p_wr_fault_src) // [R16]
    else $error("first control register did not take the write");

  property p_wr_range;
    clkEn && regWrEn && regAddr == lcc_pkg::ADDR_RANGE_SMP
      ##1 clkEn && regRdEn && regAddr == lcc_pkg::ADDR_RANGE_SMP
      |=> regRdData == ($past(regWrData, 2) & lcc_pkg::MASK_RANGE_SMP);
  endproperty
  a_wr_range: assert property (p_wr_range) // [R16]
    else $error("second control register readback mismatch");

  property p_oc_ignored;
    clkEn && !ocEn && faultIn == 2'h0 && faultLatched == 2'h0
      |=> faultLatched == 2'h0;
  endproperty
  a_oc_ignored: assert property (p_oc_ignored) // [R1]
    else $error("overcurrent latched a fault while detection disabled");

  property p_lamp_dir;
    clkEn && !pdNow |=> lampSyncOeN == $past(lampSrcSel);
  endproperty
  a_lamp_dir: assert property (p_lamp_dir) // [R3]
    else $error("lamp sync pin direction does not follow its select");

  property p_ramp_out;
    clkEn && !pdNow && !dimSigSel && rampSel
      |=> !dimSyncOeN && dimSyncPinOut == $past(rampInt);
  endproperty
  a_ramp_out: assert property (p_ramp_out) // [R5]
    else $error("dim sync pin not driven with ramp output");

  sequence s_ext_dim_high;
    (clkEn && dimSigSel && !burstDis && dimSyncPinIn) [*3];
  endsequence
  property p_ext_dim;
    s_ext_dim_high |=> burstDimPwm;
  endproperty
  a_ext_dim: assert property (p_ext_dim) // [R4]
    else $error("external dimming level not passed through");

  property p_scope_both;
    clkEn && !pdNow && scopeSel && faultLatched != 2'h0 && !retryPulse
      |=> chanShutdown == 2'h3;
  endproperty
  a_scope_both: assert property (p_scope_both) // [R7]
    else $error("fault on one channel did not stop both");

  property p_retry_off;
    clkEn && !pdNow && retryDis && faultLatched[0] |=> faultLatched[0];
  endproperty
  a_retry_off: assert property (p_retry_off) // [R6]
    else $error("fault cleared while autoretry disabled");

  property p_mem_block;
    clkEn && userMemWrReq && !memPermit
      |=> userMemWrReject && !userMemWrAccept;
  endproperty
  a_mem_block: assert property (p_mem_block) // [R9]
    else $error("user memory write not rejected");

  property p_powerdown;
    clkEn && pdNow
      |=> controllerReset && faultLatched == 2'h0 && chanShutdown == 2'h3;
  endproperty
  a_powerdown: assert property (p_powerdown) // [R15]
    else $error("power-down did not reset controller and faults");

endmodule // lamp_ctrl_config_regs
`default_nettype wire

// *** lamp_ctrl_config_regs_bench.sv ***
// Self-checking testbench for the lamp controller configuration registers.
`timescale 1ns/1ps
`default_nettype none
module lamp_ctrl_config_regs_bench;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic       regWrEn = 1'b0;
  logic [7:0] regWrData = 8'h00;
  logic       regRdEn = 1'b0;
  logic       powerdownPin = 1'b0;
  logic       dimOscPinIn = 1'b0;
  logic       lampSyncPinIn = 1'b0;
  logic       dimSyncPinIn = 1'b0;
  logic       lampFreqInt = 1'b0;
  logic       burstPwmInt = 1'b0;
  logic       rampInt = 1'b0;
  logic [1:0] faultIn = 2'h0;
  logic [1:0] overcurrentIn = 2'h0;
  logic       retryPulse = 1'b0;
  logic       userMemWrReq = 1'b0;
  logic [7:0] regRdData;
  logic       lampSyncPinOut, lampSyncOeN, dimSyncPinOut, dimSyncOeN;
  logic       controllerReset, dimOscExternal, dimOscExtClk, lampFreq;
  logic       burstDimPwm, retryEnable, userMemWrAccept, userMemWrReject;
  logic       sampleStrobe;
  logic [3:0] dimBandK;
  logic [1:0] chanShutdown;
  int         n_errors = 0;
  int         n_tests = 0;
  int         regModel [2] = '{32'h0000_0000, 32'h0000_0008};
  int         strobeCount = 0;
  logic       lampRun = 1'b0;
  logic [7:0] rnd;
  logic [7:0] rnd2;

  lamp_ctrl_config_regs i_lamp_ctrl_config_regs (.clk(clk), .sys_rst(sys_rst),
    .clkEn(clkEn), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData),
    .powerdownPin(powerdownPin), .dimOscPinIn(dimOscPinIn),
    .lampSyncPinIn(lampSyncPinIn), .lampSyncPinOut(lampSyncPinOut),
    .lampSyncOeN(lampSyncOeN), .dimSyncPinIn(dimSyncPinIn),
    .dimSyncPinOut(dimSyncPinOut), .dimSyncOeN(dimSyncOeN),
    .lampFreqInt(lampFreqInt), .burstPwmInt(burstPwmInt), .rampInt(rampInt),
    .faultIn(faultIn), .overcurrentIn(overcurrentIn), .retryPulse(retryPulse),
    .userMemWrReq(userMemWrReq), .controllerReset(controllerReset),
    .dimOscExternal(dimOscExternal), .dimOscExtClk(dimOscExtClk),
    .dimBandK(dimBandK), .lampFreq(lampFreq), .burstDimPwm(burstDimPwm),
    .retryEnable(retryEnable), .chanShutdown(chanShutdown),
    .userMemWrAccept(userMemWrAccept), .userMemWrReject(userMemWrReject),
    .sampleStrobe(sampleStrobe));

  always #5 clk = ~clk;

  // The lamp oscillator toggles every cycle, so one lamp period is two clocks.
  always @(posedge clk) begin
    if (lampRun) lampFreqInt <= ~lampFreqInt;
    if (sampleStrobe === 1'b1) strobeCount <= strobeCount + 1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // A spare cycle after each strobe keeps two transfers from meeting in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
    step(1);
    if (a == lcc_pkg::ADDR_FAULT_SRC) regModel[0] = d;
    if (a == lcc_pkg::ADDR_RANGE_SMP) regModel[1] = d & lcc_pkg::MASK_RANGE_SMP;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    step(1);
    regRdEn = 1'b0;
    chk(regRdData, exp);
    step(1);
  endtask

  // Shutdown expected from the fault inputs, overcurrent enable and scope.
  task automatic fault(input logic [7:0] cfg, input logic [1:0] f,
                       input logic [1:0] oc);
    logic [1:0] hit;
    logic [1:0] exp;
    hit = f | (oc & {2{cfg[0]}});
    exp = (cfg[6] && hit != 2'h0) ? 2'h3 : hit;
    wr(lcc_pkg::ADDR_FAULT_SRC, cfg);
    faultIn = f;
    overcurrentIn = oc;
    step(1);
    faultIn = 2'h0;
    overcurrentIn = 2'h0;
    step(3);
    chk(8'(chanShutdown), 8'(exp));
    retryPulse = 1'b1;
    step(1);
    retryPulse = 1'b0;
    step(3);
    chk(8'(chanShutdown), cfg[5] ? 8'(exp) : 8'h00);
  endtask

  task automatic finish_test();
    $display("Comparisons: %0d, mismatches: %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #100_000;
    n_errors++;
    finish_test();
  end

  initial begin
    static logic [7:0] fc [5] = '{8'h00, 8'h40, 8'h00, 8'h01, 8'h20};
    static logic [1:0] ff [5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h2};
    static logic [1:0] fo [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
    int         base;
    int         got;
    int         exp;
    void'($urandom(32'h9db2_a1e4));
    step(12);
    sys_rst = 1'b0;
    step(2);
    rd(lcc_pkg::ADDR_FAULT_SRC, 8'(regModel[0]));
    rd(lcc_pkg::ADDR_RANGE_SMP, 8'(regModel[1]));
    rd(8'h00F6, 8'h00);
    chk(8'(dimBandK), 8'h01);
    chk(8'(retryEnable), 8'h01);
    // A read right behind a write, then a write while the enable is low.
    regAddr = lcc_pkg::ADDR_RANGE_SMP;
    regWrData = 8'h66;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
    regRdEn = 1'b1;
    regModel[1] = 8'h66 & lcc_pkg::MASK_RANGE_SMP;
    step(1);
    regRdEn = 1'b0;
    chk(regRdData, 8'(regModel[1]));
    clkEn = 1'b0;
    regAddr = lcc_pkg::ADDR_FAULT_SRC;
    regWrData = 8'hFF;
    regWrEn = 1'b1;
    step(1);
    regWrEn = 1'b0;
    clkEn = 1'b1;
    step(1);
    rd(lcc_pkg::ADDR_FAULT_SRC, 8'(regModel[0]));
    for (int i = 0; i < 8; i++) begin
      rnd = 8'($urandom());
      rnd2 = 8'($urandom()) & 8'h7F;
      wr(lcc_pkg::ADDR_FAULT_SRC, rnd);
      wr(lcc_pkg::ADDR_RANGE_SMP, rnd2);
      wr(8'h00F6, ~rnd);
      step(2);
      chk(8'(retryEnable), 8'(!rnd[5]));
      chk(8'(dimOscExternal), 8'(rnd[1]));
      chk(8'(lampSyncOeN), 8'(rnd[2]));
      chk(8'(dimSyncOeN), 8'(rnd[3]));
      chk(8'(dimBandK), 8'(4'h1 << rnd2[2:1]));
      if (rnd[7]) chk(8'(burstDimPwm), 8'h01);
      rd(lcc_pkg::ADDR_FAULT_SRC, 8'(regModel[0]));
      rd(lcc_pkg::ADDR_RANGE_SMP, 8'(regModel[1]));
    end
    wr(lcc_pkg::ADDR_RANGE_SMP, 8'h08);
    rampInt = 1'b1;
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h10);
    step(2);
    chk(8'(dimSyncPinOut), 8'h01);
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h00);
    step(2);
    chk(8'(dimSyncPinOut), 8'h00);
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h80);
    step(2);
    chk(8'(burstDimPwm), 8'h01);
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h00);
    step(2);
    chk(8'(burstDimPwm), 8'h00);
    dimSyncPinIn = 1'b1;
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h08);
    step(5);
    chk(8'(burstDimPwm), 8'h01);
    lampSyncPinIn = 1'b1;
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h04);
    step(5);
    chk(8'(lampFreq), 8'h01);
    lampSyncPinIn = 1'b0;
    dimOscPinIn = 1'b1;
    // The external dimming clock is taken to lie in the lowest band.
    wr(lcc_pkg::ADDR_RANGE_SMP, 8'h08);
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h02);
    step(5);
    chk(8'(lampFreq), 8'h00);
    chk(8'(dimOscExtClk), 8'h01);
    wr(lcc_pkg::ADDR_FAULT_SRC, 8'h00);
    step(2);
    chk(8'(dimOscExtClk), 8'h00);
    for (int i = 0; i < 5; i++) fault(fc[i], ff[i], fo[i]);
    for (int p = 0; p < 2; p++) begin
      wr(lcc_pkg::ADDR_RANGE_SMP, 8'h08 | 8'(p));
      userMemWrReq = 1'b1;
      step(1);
      userMemWrReq = 1'b0;
      chk(8'(userMemWrAccept), 8'(p));
      chk(8'(userMemWrReject), 8'(1 - p));
      step(1);
    end
    for (int c = 0; c < 4; c++) begin
      wr(lcc_pkg::ADDR_RANGE_SMP, 8'(c << 3));
      base = strobeCount;
      lampRun = 1'b1;
      step(128);
      chk(8'(lampSyncPinOut), 8'(!lampFreqInt));
      lampRun = 1'b0;
      got = strobeCount - base;
      exp = 64 / (4 << c);
      // The divider phase is unknown after a rate change, so allow one sample.
      chk(8'((got >= exp - 1 && got <= exp + 1) ? exp : got), 8'(exp));
    end
    wr(lcc_pkg::ADDR_RANGE_SMP, 8'h88);
    step(2);
    chk(8'(controllerReset), 8'h01);
    chk(8'({lampSyncOeN, dimSyncOeN}), 8'h03);
    chk(8'(chanShutdown), 8'h03);
    rd(lcc_pkg::ADDR_RANGE_SMP, 8'h88);
    wr(lcc_pkg::ADDR_RANGE_SMP, 8'h08);
    step(2);
    chk(8'(controllerReset), 8'h00);
    chk(8'(chanShutdown), 8'h00);
    powerdownPin = 1'b1;
    step(5);
    chk(8'(controllerReset), 8'h01);
    powerdownPin = 1'b0;
    step(5);
    chk(8'(controllerReset), 8'h00);
    finish_test();
  end
endmodule // lamp_ctrl_config_regs_bench
`default_nettype wire
